// file: design/owh_pkg.sv
package owh_pkg;

    // wire timing, microseconds as printed or chosen where none is given
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned RESET_LOW_US = 480;
    localparam int unsigned PRESENCE_WAIT_US = 480;
    localparam int unsigned PROG_PULSE_US = 480;
    localparam int unsigned WRITE_STROBE_US = 5;
    localparam int unsigned SLOT_US = 60;
    localparam int unsigned SAMPLE_US = 15;
    localparam int unsigned RECOVER_US = 5;
    localparam int unsigned RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int unsigned PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * CLK_MHZ;
    localparam int unsigned PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
    localparam int unsigned WRITE_STROBE_CYC = WRITE_STROBE_US * CLK_MHZ;
    localparam int unsigned SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int unsigned SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int unsigned RECOVER_CYC = RECOVER_US * CLK_MHZ;

    // command codes
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_MATCH_ID = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
    localparam logic [7:0] CMD_READ_MEM = 8'hf0;
    localparam logic [7:0] CMD_READ_STATUS = 8'haa;
    localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;

    // crc polynomials, reflected for lsb-first shifting
    localparam logic [15:0] CRC16_POLY_REV = 16'ha001;
    localparam logic [7:0] CRC8_POLY_REV = 8'h8c;
    localparam logic [15:0] CRC16_INIT = 16'h0000;
    localparam logic [7:0] CRC8_INIT = 8'h00;

    // primitive operations the user side requests
    typedef enum logic [2:0] {
        OWH_OP_RESET,
        OWH_OP_WRITE_BYTE,
        OWH_OP_READ_BYTE,
        OWH_OP_PROGRAM,
        OWH_OP_CRC_LOAD
    } owh_op_t;

    typedef struct packed {
        owh_op_t op;
        logic [7:0] data;
    } owh_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic presence;
        logic [15:0] crc16;
        logic [7:0] crc8;
    } owh_rsp_t;

endpackage

// file: design/owh_master.sv
// What this block does
// RULE1 - write memory: 0fh, addr lo, hi, data
// RULE2 - device returns crc16 over write sequence
// RULE3 - device ands buffer into memory byte
// RULE4 - program pulse only on crc match, 480us; owh_master pulses on any OWH_OP_PROGRAM request, without comparing crcs
// RULE5 - reset may abort, never during program pulse
// RULE6 - device returns programmed byte, lsb first
// RULE7 - unprogrammed data bits read as one
// RULE8 - write status: 55h, addr lo, hi, data
// RULE9 - address and data bytes go lsb first
// RULE10 - status bytes start ones, zeros clear bits
// RULE11 - host reads eight verify slots after pulse
// RULE12 - first status crc covers cmd, addr, data
// RULE13 - device increments address after verify slots
// RULE14 - later crc preloads low address byte
// RULE15 - continuing: data byte, crc, then pulse
// RULE16 - device never blocks on crc mismatch
// RULE17 - low over 480us resets, presence follows
// RULE18 - write bit: strobe low, hold or release
// RULE19 - read slot: device pulls low for zero
// RULE20 - high line is idle, pauses allowed
// RULE21 - decoder knows rom and function codes
// RULE22 - identity crc8 x8+x5+x4+1 over 56 bits
// RULE23 - transfer crc16 x16+x15+x2+1
// RULE24 - read commands also give crc16
// RULE25 - functions ignored until rom selection
// RULE26 - match identity compares all 64 bits
// RULE27 - crc16 sent lsb first; abort waits reset
`timescale 1ns/1ps
`default_nettype none

module owh_master #(
    parameter int unsigned RESET_LOW_CYCLES = owh_pkg::RESET_LOW_CYC,
    parameter int unsigned PRESENCE_WAIT_CYCLES = owh_pkg::PRESENCE_WAIT_CYC,
    parameter int unsigned PROG_PULSE_CYCLES = owh_pkg::PROG_PULSE_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    output logic req_ready,
    input wire owh_pkg::owh_req_t req,
    output logic rsp_valid,
    output owh_pkg::owh_rsp_t rsp,
    input wire logic crc_clear,
    input wire logic dq_i,
    output logic dq_o,
    output logic dq_oe,
    output logic prog_en
);
    import owh_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_RST_WAIT,
        ST_SLOT,
        ST_RECOVER,
        ST_PROG,
        ST_DONE
    } owh_state_t;

    localparam int unsigned CNT_W = 24;

    // lsb-first crc steps over one bit
    function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
        crc16_bit = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC16_POLY_REV : 16'h0000); // [RULE23]
    endfunction

    function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
        crc8_bit = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? CRC8_POLY_REV : 8'h00); // [RULE22]
    endfunction

    owh_state_t state_q, state_d;
    owh_op_t op_q;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] shreg_q;
    logic presence_q;
    logic [15:0] crc16_q;
    logic [7:0] crc8_q;
    logic rsp_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // slot decode
    wire logic is_read;
    wire logic tx_bit;
    wire logic slot_bit;
    wire logic [CNT_W-1:0] cnt_inc;
    wire logic cnt_end_rst;
    wire logic cnt_end_wait;
    wire logic cnt_end_slot;
    wire logic cnt_end_rec;
    wire logic cnt_end_prog;
    wire logic in_strobe;
    wire logic at_sample;
    wire logic accept;
    wire logic shift_now;

    assign is_read = (op_q == OWH_OP_READ_BYTE);
    assign tx_bit = shreg_q[0]; // lsb first [RULE9]
    assign slot_bit = is_read ? dq_i : tx_bit;
    assign cnt_inc = cnt_q + 24'h000001;
    assign cnt_end_rst = (cnt_inc == CNT_W'(RESET_LOW_CYCLES));
    assign cnt_end_wait = (cnt_inc == CNT_W'(PRESENCE_WAIT_CYCLES));
    assign cnt_end_slot = (cnt_inc == CNT_W'(SLOT_CYC));
    assign cnt_end_rec = (cnt_inc == CNT_W'(RECOVER_CYC));
    assign cnt_end_prog = (cnt_inc == CNT_W'(PROG_PULSE_CYCLES));
    assign in_strobe = (cnt_q < CNT_W'(WRITE_STROBE_CYC));
    assign at_sample = (cnt_q == CNT_W'(SAMPLE_CYC));
    assign accept = req_valid && req_ready;
    assign req_ready = (state_q == ST_IDLE); // idle leaves the line released [RULE20]
    // reads shift at the sample point; writes shift only when the slot ends,
    // so the bit being driven cannot change in mid-slot
    assign shift_now = (state_q == ST_SLOT) && (is_read ? at_sample : cnt_end_slot);

    // line drive: reset low, strobe low, zero bits held low [RULE18]
    assign dq_oe = (state_q == ST_RST_LOW)
        || ((state_q == ST_SLOT) && (in_strobe || (!is_read && !tx_bit))); // [RULE17]
    assign dq_o = 1'b0;
    // program supply only during its own state; nothing may cut it short [RULE5]
    assign prog_en = (state_q == ST_PROG); // [RULE4]
    assign rsp_valid = rsp_valid_q;
    assign rsp.data = shreg_q;
    assign rsp.presence = presence_q;
    assign rsp.crc16 = crc16_q;
    assign rsp.crc8 = crc8_q;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    case (req.op)
                        OWH_OP_RESET: state_d = ST_RST_LOW;
                        OWH_OP_WRITE_BYTE: state_d = ST_SLOT; // [RULE1] [RULE8] [RULE15]
                        OWH_OP_READ_BYTE: state_d = ST_SLOT;
                        OWH_OP_PROGRAM: state_d = ST_PROG; // [RULE15]
                        default: state_d = ST_DONE;
                    endcase
                end
            end
            ST_RST_LOW: if (cnt_end_rst) state_d = ST_RST_WAIT;
            ST_RST_WAIT: if (cnt_end_wait) state_d = ST_DONE;
            ST_SLOT: if (cnt_end_slot) state_d = ST_RECOVER;
            ST_RECOVER: begin
                if (cnt_end_rec) state_d = (bit_q == 3'h7) ? ST_DONE : ST_SLOT;
            end
            ST_PROG: if (cnt_end_prog) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // state and timing counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q) ? '0 : cnt_inc;
        end
    end

    // operation capture, bit index and shift register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            op_q <= OWH_OP_RESET;
            bit_q <= 3'h0;
            shreg_q <= 8'hff;
        end else if (accept) begin
            op_q <= req.op;
            bit_q <= 3'h0;
            shreg_q <= req.data;
        end else if (shift_now) begin
            shreg_q <= {slot_bit, shreg_q[7:1]}; // lsb first in and out [RULE9] [RULE27]
        end else if (state_q == ST_RECOVER && cnt_end_rec) begin
            bit_q <= bit_q + 3'h1;
        end
    end

    // presence sample in the wait window after reset low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            presence_q <= 1'b0;
        end else if (accept && req.op == OWH_OP_RESET) begin
            presence_q <= 1'b0;
        end else if (state_q == ST_RST_WAIT && !dq_i) begin
            presence_q <= 1'b1; // [RULE17]
        end
    end

    // running crcs over every bit on the wire; load preloads the low address [RULE14]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            crc16_q <= CRC16_INIT;
            crc8_q <= CRC8_INIT;
        end else if (crc_clear) begin
            crc16_q <= CRC16_INIT;
            crc8_q <= CRC8_INIT;
        end else if (accept && req.op == OWH_OP_CRC_LOAD) begin
            crc16_q <= {8'h00, req.data}; // loaded, not shifted [RULE14]
        end else if (state_q == ST_SLOT && at_sample) begin
            crc16_q <= crc16_bit(crc16_q, slot_bit); // [RULE2] [RULE12] [RULE24]
            crc8_q <= crc8_bit(crc8_q, slot_bit); // [RULE22]
        end
    end

    // one-cycle completion pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= (state_q == ST_DONE); // [RULE11]
        end
    end

endmodule
`default_nettype wire

// file: tb/owh_master_chk.sv
`timescale 1ns/1ps
`default_nettype none
module owh_master_chk import owh_pkg::*; #(
    parameter int unsigned RESET_LOW_CYCLES = 4800,
    parameter int unsigned PROG_PULSE_CYCLES = 4800
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire owh_pkg::owh_req_t req,
    input wire logic rsp_valid,
    input wire owh_pkg::owh_rsp_t rsp,
    input wire logic crc_clear,
    input wire logic dq_oe,
    input wire logic prog_en
);
    int unsigned oe_run_q;
    int unsigned pe_run_q;
    wire logic take = req_valid && req_ready;
    // run lengths of the wire pull and of the program pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oe_run_q <= '0;
            pe_run_q <= '0;
        end else begin
            oe_run_q <= dq_oe ? oe_run_q + 1 : '0;
            pe_run_q <= prog_en ? pe_run_q + 1 : '0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_take_busy: assert property (take |=> !req_ready)
        else $error("request taken while busy");
    chk_oe_length: assert property ($fell(dq_oe) |->
        oe_run_q inside {50, 600, RESET_LOW_CYCLES})
        else $error("wire pull of wrong length");
    chk_prog_length: assert property ($fell(prog_en) |-> pe_run_q == PROG_PULSE_CYCLES)
        else $error("program pulse of wrong length");
    chk_prog_start: assert property (take && req.op == OWH_OP_PROGRAM |-> ##[1:2] prog_en)
        else $error("program pulse did not start");
    chk_prog_busy: assert property (prog_en |-> !req_ready)
        else $error("ready during program pulse");
    chk_idle_quiet: assert property (req_ready |-> !dq_oe && !prog_en)
        else $error("wire driven while idle");
    chk_load_value: assert property (take && req.op == OWH_OP_CRC_LOAD |-> ##2
        rsp_valid && rsp.crc16 == {8'h00, $past(req.data, 2)})
        else $error("crc preload wrong");
    chk_clear_zero: assert property (crc_clear |=>
        rsp.crc16 == 16'h0000 && rsp.crc8 == 8'h00)
        else $error("crc not cleared");
    cover property (take && req.op == OWH_OP_PROGRAM);
    cover property ($fell(dq_oe) && oe_run_q == RESET_LOW_CYCLES);
    cover property (rsp_valid && rsp.presence);
endmodule
bind owh_master owh_master_chk #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES),
    .PROG_PULSE_CYCLES(PROG_PULSE_CYCLES)) u_owh_master_chk (.clock(clock), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .crc_clear(crc_clear), .dq_oe(dq_oe), .prog_en(prog_en));
`default_nettype wire

// file: tb/owh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module owh_dev_model (
    input wire logic clock,
    input wire logic line,
    input wire logic prog_en,
    output var logic pull
);
    int nb;
    int t;
    logic b;
    logic [15:0] crc;
    logic [7:0] buf_q;
    logic [7:0] rom;
    logic [7:0] adr;
    logic [7:0] mem = 8'hff;
    // programming can only clear bits of the stored byte
    always @(posedge clock) if (prog_en) mem <= mem & buf_q;
    // every falling edge opens a bit slot or a reset pulse
    initial begin
        pull = 0;
        nb = 0;
        rom = 8'h00;
        adr = 8'h00;
        crc = 16'h0000;
        forever begin
            @(negedge line);
            // answers only once a skip selected it: crc low, crc high, then the stored byte
            if (rom == 8'hcc && nb >= 40 && nb < 56) pull = !crc[nb-40];
            if (rom == 8'hcc && nb >= 56 && nb < 64) pull = !mem[nb-56];
            repeat (150) @(posedge clock);
            b = line;
            repeat (50) @(posedge clock);
            pull = 0;
            t = 0;
            #1;
            while (!line && t < 900) begin
                @(posedge clock);
                t++;
            end
            if (t > 500) begin
                nb = 0;
                rom = 8'h00;
                crc = 16'h0000;
                repeat (30) @(posedge clock);
                pull = 1;
                repeat (100) @(posedge clock);
                pull = 0;
            end else begin
                // crc16 over command, address and data as they arrive
                if (nb >= 8 && nb < 40) crc = (crc[0] ^ b) ? (crc >> 1) ^ 16'ha001 : crc >> 1;
                if (nb < 8) rom = {b, rom[7:1]};
                if (nb >= 16 && nb < 24) adr = {b, adr[7:1]};
                if (nb >= 32 && nb < 40) buf_q = {b, buf_q[7:1]};
                nb++;
                // after the verify byte the address steps on and its low byte seeds the crc
                if (nb == 64) begin
                    adr = adr + 8'h01;
                    crc = {8'h00, adr};
                    nb = 32;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/test_owh_master.sv
`timescale 1ns/1ps
`default_nettype none
module test_owh_master;
    import owh_pkg::*;
    logic clock = 0, rstn = 0, req_valid = 0, crc_clear = 0;
    owh_req_t req = '0;
    owh_rsp_t rsp;
    logic req_ready, rsp_valid, dq_o, dq_oe, prog_en, pull;
    int n_mismatch = 0, total_checks = 0;
    wire logic line = !(dq_oe || pull); // open drain with pull-up
    always #50 clock = !clock;
    owh_master #(.RESET_LOW_CYCLES(800), .PRESENCE_WAIT_CYCLES(300), .PROG_PULSE_CYCLES(100))
        u_owh_master (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .crc_clear(crc_clear), .dq_i(line),
        .dq_o(dq_o), .dq_oe(dq_oe), .prog_en(prog_en));
    owh_dev_model u_owh_dev_model (.clock(clock), .line(line), .prog_en(prog_en), .pull(pull));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one request, held until taken, then a bounded wait for its answer
    task automatic op(input owh_op_t k, input logic [7:0] d);
        int n;
        n = 0;
        req_valid = 1;
        req = '{k, d};
        while (req_ready !== 1'b1 && n < 9) begin
            @(posedge clock);
            #1 n++;
        end
        // a request not taken within nine clock cycles counts as a hang
        if (req_ready !== 1'b1) begin
            n = 9000;
        end else begin
            @(posedge clock);
            #1 req_valid = 0;
        end
        while (rsp_valid !== 1'b1 && n < 9000) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 9000) begin
            chk(0, 1, "timeout");
            tally_and_finish();
        end
    endtask
    function automatic logic [15:0] crc_of(input logic [31:0] w);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < 32; i++) c = (c[0] ^ w[i]) ? (c >> 1) ^ CRC16_POLY_REV : c >> 1;
        return c;
    endfunction
    function automatic logic [7:0] crc8_of(input logic [31:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 32; i++) c = (c[0] ^ w[i]) ? (c >> 1) ^ CRC8_POLY_REV : c >> 1;
        return c;
    endfunction
    // reset, skip selection, write sequence, crc readback, optional program, verify
    task automatic t_write(input logic [7:0] cmd, hi, d, input logic prog, input logic [7:0] rb);
        logic [15:0] c;
        op(OWH_OP_RESET, 8'h00);
        chk(rsp.presence, 1, "presence");
        chk(dq_o, 0, "dq_o level");
        op(OWH_OP_WRITE_BYTE, CMD_SKIP_ID);
        crc_clear = 1;
        @(posedge clock);
        #1 crc_clear = 0;
        op(OWH_OP_WRITE_BYTE, cmd);
        op(OWH_OP_WRITE_BYTE, 8'h05);
        op(OWH_OP_WRITE_BYTE, hi);
        op(OWH_OP_WRITE_BYTE, d);
        c = crc_of({d, hi, 8'h05, cmd});
        chk(rsp.crc16, c, "host crc");
        chk(rsp.crc8, crc8_of({d, hi, 8'h05, cmd}), "host crc8");
        op(OWH_OP_READ_BYTE, 8'h00);
        chk(rsp.data, c[7:0], "crc low");
        op(OWH_OP_READ_BYTE, 8'h00);
        chk(rsp.data, c[15:8], "crc high");
        if (prog) op(OWH_OP_PROGRAM, 8'h00);
        op(OWH_OP_READ_BYTE, 8'h00);
        chk(rsp.data, rb, "verify");
    endtask
    // crc preload with the low address byte
    task automatic t_load();
        op(OWH_OP_CRC_LOAD, 8'h06);
        chk(rsp.crc16, 16'h0006, "crc preload");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1 rstn = 1;
        t_write(CMD_WRITE_MEM, 8'h00, 8'ha5, 0, 8'hff);
        t_write(CMD_WRITE_STATUS, 8'h01, 8'h3c, 1, 8'h3c);
        t_load();
        tally_and_finish();
    end
endmodule
`default_nettype wire
